//--- flash_wp_pkg.sv
// Shared constants and types for the serial flash protection and status logic
package flash_wp_pkg;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] OP_SET_WEL     = 8'h06;
  localparam logic [7:0] OP_CLR_WEL     = 8'h04;
  localparam logic [7:0] OP_STAT_RD     = 8'h05;
  localparam logic [7:0] OP_STAT_WR     = 8'h01;
  localparam logic [7:0] OP_PAGE_PROG   = 8'h02;
  localparam logic [7:0] OP_ERASE_4K    = 8'h20;
  localparam logic [7:0] OP_ERASE_32K   = 8'h52;
  localparam logic [7:0] OP_ERASE_64K   = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE1 = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE2 = 8'hc7;
  localparam logic [7:0] OP_DEEP_SLEEP  = 8'hb9;
  localparam logic [7:0] OP_WAKE        = 8'hab;
  localparam logic [7:0] OP_DUAL_READ   = 8'h3b;

  // ****************************************************************
  // Status register layout and reset values
  // ****************************************************************
  localparam int         ST_LOCK_BIT  = 7;
  localparam int         ST_SEL_MSB   = 4;
  localparam int         ST_SEL_LSB   = 2;
  localparam int         ST_WEL_BIT   = 1;
  localparam int         ST_BUSY_BIT  = 0;
  localparam logic       LOCK_RESET   = 1'b0;
  localparam logic [2:0] SEL_RESET    = 3'h0;
  localparam logic       WEL_RESET    = 1'b0;
  localparam logic       BUSY_RESET   = 1'b0;

  // ****************************************************************
  // Least frame lengths in whole bytes
  // ****************************************************************
  localparam logic [2:0] BYTES_CMD     = 3'h1;
  localparam logic [2:0] BYTES_STAT_WR = 3'h2;
  localparam logic [2:0] BYTES_ERASE   = 3'h4;
  localparam logic [2:0] BYTES_PROG    = 3'h5;
  localparam logic [2:0] BYTES_ADDR    = 3'h3;
  localparam logic [2:0] BYTES_DUAL    = 3'h4;

  // ****************************************************************
  // Protected range tops per protect_sel code
  // ****************************************************************
  localparam logic [23:0] TOP4_SEL1 = 24'h07dfff;
  localparam logic [23:0] TOP4_SEL2 = 24'h07bfff;
  localparam logic [23:0] TOP4_SEL3 = 24'h077fff;
  localparam logic [23:0] TOP4_SEL4 = 24'h06ffff;
  localparam logic [23:0] TOP4_SEL5 = 24'h05ffff;
  localparam logic [23:0] TOP4_SEL6 = 24'h03ffff;
  localparam logic [23:0] TOP4_ALL  = 24'h07ffff;
  localparam logic [23:0] TOP2_SEL1 = 24'h03dfff;
  localparam logic [23:0] TOP2_SEL2 = 24'h03bfff;
  localparam logic [23:0] TOP2_SEL3 = 24'h037fff;
  localparam logic [23:0] TOP2_SEL4 = 24'h02ffff;
  localparam logic [23:0] TOP2_SEL5 = 24'h01ffff;
  localparam logic [23:0] TOP2_ALL  = 24'h03ffff;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          SYS_CLK_NS   = 40;
  localparam int          BUSY_TIME_NS = 2000;
  localparam logic [15:0] BUSY_CYCLES  =
    16'((BUSY_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    AOP_NONE, AOP_PROG, AOP_ERASE_4K, AOP_ERASE_32K, AOP_ERASE_64K, AOP_ERASE_CHIP
  } array_op_t;

  typedef enum logic [1:0] {TX_NONE, TX_STATUS, TX_DUAL} tx_mode_t;

endpackage

//--- flash_wp_status.sv
// Serial flash status register, write latch, protection and command gating
`timescale 1ns/100ps
module flash_wp_status
  import flash_wp_pkg::*;
#(
  parameter bit DENSITY_4M = 1'b1
)
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        sclk_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        write_protect_n_i,
  input  wire logic        dual_lane0_i,
  output logic             dual_lane0_o,
  output logic             dual_lane0_oe_o,
  output logic             dual_lane1_o,
  output logic             dual_lane1_oe_o,
  input  wire logic [7:0]  array_rdata_i,
  output logic [23:0]      array_raddr_o,
  output logic [2:0]       array_op_o,
  output logic [23:0]      array_addr_o,
  output logic [7:0]       flash_status_o,
  output logic             deep_sleep_o
);

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef struct packed {
    logic [2:0]  cs_sync;
    logic [1:0]  wp_sync;
    logic        tog_seen;
    logic        lock;
    logic [2:0]  sel;
    logic        write_enable_latch;
    logic        busy;
    logic [15:0] busy_cnt;
    logic        sleep;
    array_op_t   op;
    logic [23:0] op_addr;
  } sys_t;

  typedef struct packed {
    logic        frame_tog;
    logic [7:0]  shreg;
    logic [2:0]  bitcnt;
    logic [2:0]  bytecnt;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  tx;
    tx_mode_t    mode;
    logic [1:0]  dphase;
    logic [23:0] raddr;
    logic [7:0]  st_s1;
    logic [7:0]  st_s2;
    logic [7:0]  st_s3;
    logic [7:0]  st_hold;
    logic        sl_s1;
    logic        sl_s2;
  } link_t;

  typedef struct packed {
    logic lane0;
    logic lane0_oe;
    logic lane1;
    logic lane1_oe;
  } drive_t;

  function automatic logic [7:0] pack_status(input logic lock, input logic [2:0] sel,
                                             input logic write_enable_latch, input logic busy);
    logic [7:0] s;
    s = 8'h00;
    s[ST_LOCK_BIT]            = lock;
    s[ST_SEL_MSB:ST_SEL_LSB]  = sel;
    s[ST_WEL_BIT]             = write_enable_latch;
    s[ST_BUSY_BIT]            = busy;
    return s;
  endfunction

  sys_t   s_reg, s_next;
  link_t  l_reg, l_next;
  drive_t d_reg, d_next;
  logic   fresh_reg;
  logic   prot_hit;

  protect_decode u_protect (
    .sel_i     (s_reg.sel),
    .dens_4m_i (DENSITY_4M),
    .addr_i    (l_reg.addr),
    .hit_o     (prot_hit)
  );

  // ****************************************************************
  // Link side: shift in on rising edge
  // ****************************************************************
  // The serial clock stops between frames, so a new frame is detected by
  // a flag that chip select sets and the first rising edge clears.
  always_ff @(posedge sclk_i or posedge chip_select_n_i or posedge rst_i) begin
    if (chip_select_n_i || rst_i) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  always_comb begin
    logic [7:0] nb;
    logic       full;
    l_next = l_reg;
    nb     = {l_reg.shreg[6:0], dual_lane0_i};
    if (fresh_reg) begin
      l_next.frame_tog = ~l_reg.frame_tog;
      l_next.bitcnt    = 3'h0;
      l_next.bytecnt   = 3'h0;
      l_next.mode      = TX_NONE;
      l_next.dphase    = 2'h0;
      nb               = {7'h00, dual_lane0_i};
    end
    full            = (l_next.bitcnt == 3'h7);
    l_next.shreg    = nb;
    l_next.st_s1    = flash_status_o;
    l_next.st_s2    = l_reg.st_s1;
    l_next.st_s3    = l_reg.st_s2;
    l_next.sl_s1    = deep_sleep_o;
    l_next.sl_s2    = l_reg.sl_s1;
    // A status word is taken only once two samples agree
    if (l_reg.st_s2 == l_reg.st_s3) begin
      l_next.st_hold = l_reg.st_s3;
    end
    l_next.bitcnt = 3'(l_next.bitcnt + 3'h1);
    if (full) begin
      if (l_next.bytecnt == 3'h0) begin
        l_next.opcode = nb;
      end else if (l_next.bytecnt <= BYTES_ADDR) begin
        l_next.addr = {l_reg.addr[15:0], nb};
      end
      if (l_next.bytecnt == BYTES_CMD) begin
        l_next.wdata = nb;
      end
      if (l_next.bytecnt == BYTES_ADDR && l_next.opcode == OP_DUAL_READ) begin
        l_next.raddr = {l_reg.addr[15:0], nb};
      end
      if (l_next.bytecnt == 3'h0 && nb == OP_STAT_RD && !l_reg.sl_s2) begin
        l_next.mode = TX_STATUS;
      end
      if (l_next.bytecnt == BYTES_DUAL && l_next.opcode == OP_DUAL_READ
          && !l_reg.sl_s2 && l_next.mode == TX_NONE) begin
        l_next.mode   = TX_DUAL;
        l_next.tx     = array_rdata_i;
        l_next.raddr  = 24'(l_reg.raddr + 24'h1);
        l_next.dphase = 2'h3;
      end
      if (l_next.bytecnt != 3'h7) begin
        l_next.bytecnt = 3'(l_next.bytecnt + 3'h1);
      end
    end
    if (l_next.mode == TX_STATUS && full) begin
      l_next.tx = l_reg.st_hold;
    end
    if (l_reg.mode == TX_DUAL && !fresh_reg) begin
      l_next.dphase = 2'(l_reg.dphase + 2'h1);
      if (l_reg.dphase == 2'h3) begin
        l_next.tx    = array_rdata_i;
        l_next.raddr = 24'(l_reg.raddr + 24'h1);
      end
    end else if (l_next.mode == TX_DUAL && l_reg.mode != TX_DUAL) begin
      l_next.dphase = 2'h0;
    end
  end

  // The frame toggle must start known, or no frame end is ever accepted.
  // The serial clock is stopped while reset is held, so the asynchronous
  // reset meets no edge; both sides start the toggle at zero together.
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  // ****************************************************************
  // Link side: drive out on falling edge
  // ****************************************************************
  always_comb begin
    d_next = '0;
    case (l_reg.mode)
      TX_STATUS: begin
        d_next.lane1    = l_reg.tx[~l_reg.bitcnt];
        d_next.lane1_oe = 1'b1;
      end
      TX_DUAL: begin
        d_next.lane1    = l_reg.tx[{~l_reg.dphase, 1'b1}];
        d_next.lane0    = l_reg.tx[{~l_reg.dphase, 1'b0}];
        d_next.lane1_oe = 1'b1;
        d_next.lane0_oe = 1'b1;
      end
      default: d_next = '0;
    endcase
  end

  // Mode 0 and mode 3 differ only in the idle level of the clock
  always_ff @(negedge sclk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      d_reg <= '0;
    end else begin
      d_reg <= d_next;
    end
  end

  // ****************************************************************
  // System side: command execution at frame end
  // ****************************************************************
  always_comb begin
    logic end_frame;
    logic whole;
    logic new_frame;
    logic hw_prot;
    logic [2:0] nbytes;
    s_next         = s_reg;
    s_next.cs_sync = {s_reg.cs_sync[1:0], chip_select_n_i};
    s_next.wp_sync = {s_reg.wp_sync[0], write_protect_n_i};
    s_next.op      = AOP_NONE;
    end_frame      = s_reg.cs_sync[1] && !s_reg.cs_sync[2];
    // Link fields are quiet once the clock stops with chip select high
    new_frame      = l_reg.frame_tog != s_reg.tog_seen;
    whole          = (l_reg.bitcnt == 3'h0);
    nbytes         = l_reg.bytecnt;
    hw_prot        = s_reg.lock && !s_reg.wp_sync[1];
    if (s_reg.busy) begin
      if (s_reg.busy_cnt == 16'h0001) begin
        s_next.busy = 1'b0;
        s_next.write_enable_latch  = 1'b0;
      end
      s_next.busy_cnt = 16'(s_reg.busy_cnt - 16'h0001);
    end
    if (end_frame && new_frame) begin
      s_next.tog_seen = l_reg.frame_tog;
      if (s_reg.sleep) begin
        if (l_reg.opcode == OP_WAKE && nbytes >= BYTES_CMD) begin
          s_next.sleep = 1'b0;
        end
      end else if (!s_reg.busy && whole && nbytes >= BYTES_CMD) begin
        case (l_reg.opcode)
          OP_SET_WEL:    s_next.write_enable_latch   = 1'b1;
          OP_CLR_WEL:    s_next.write_enable_latch   = 1'b0;
          OP_DEEP_SLEEP: s_next.sleep = 1'b1;
          OP_STAT_WR: begin
            if (s_reg.write_enable_latch && !hw_prot && nbytes >= BYTES_STAT_WR) begin
              s_next.lock     = l_reg.wdata[ST_LOCK_BIT];
              s_next.sel      = l_reg.wdata[ST_SEL_MSB:ST_SEL_LSB];
              s_next.busy     = 1'b1;
              s_next.busy_cnt = BUSY_CYCLES;
            end
          end
          OP_PAGE_PROG, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K: begin
            // erase sizes follow the address bits, so no alignment here
            if (s_reg.write_enable_latch && !prot_hit
                && nbytes >= ((l_reg.opcode == OP_PAGE_PROG) ? BYTES_PROG : BYTES_ERASE)) begin
              s_next.busy     = 1'b1;
              s_next.busy_cnt = BUSY_CYCLES;
              s_next.op_addr  = l_reg.addr;
              case (l_reg.opcode)
                OP_PAGE_PROG: s_next.op = AOP_PROG;
                OP_ERASE_4K:  s_next.op = AOP_ERASE_4K;
                OP_ERASE_32K: s_next.op = AOP_ERASE_32K;
                default:      s_next.op = AOP_ERASE_64K;
              endcase
            end
          end
          OP_CHIP_ERASE1, OP_CHIP_ERASE2: begin
            if (s_reg.write_enable_latch && s_reg.sel == 3'h0) begin
              s_next.busy     = 1'b1;
              s_next.busy_cnt = BUSY_CYCLES;
              s_next.op       = AOP_ERASE_CHIP;
              s_next.op_addr  = 24'h000000;
            end
          end
          default: s_next.write_enable_latch = s_reg.write_enable_latch;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_reg          <= '0;
      s_reg.cs_sync  <= 3'h7;
      s_reg.tog_seen <= 1'b0;
      s_reg.lock     <= LOCK_RESET;
      s_reg.sel      <= SEL_RESET;
      s_reg.write_enable_latch      <= WEL_RESET;
      s_reg.busy     <= BUSY_RESET;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign flash_status_o  = pack_status(s_reg.lock, s_reg.sel, s_reg.write_enable_latch, s_reg.busy);
  assign deep_sleep_o    = s_reg.sleep;
  assign array_op_o      = s_reg.op;
  assign array_addr_o    = s_reg.op_addr;
  assign array_raddr_o   = l_reg.raddr;
  assign dual_lane0_o    = d_reg.lane0;
  assign dual_lane0_oe_o = d_reg.lane0_oe;
  assign dual_lane1_o    = d_reg.lane1;
  assign dual_lane1_oe_o = d_reg.lane1_oe;

endmodule

//--- flash_wp_status_checker.sv
// Concurrent checks on the flash protection and status ports
`timescale 1ns/100ps
module flash_wp_status_checker
  import flash_wp_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  input wire logic       chip_select_n_i,
  input wire logic       write_protect_n_i,
  input wire logic       dual_lane0_oe_o,
  input wire logic       dual_lane1_oe_o,
  input wire logic [2:0] array_op_o,
  input wire logic [7:0] flash_status_o,
  input wire logic       deep_sleep_o
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [15:0] busy_cnt;
  wire         busy = flash_status_o[ST_BUSY_BIT];
  // Frozen cycles do not count, so a stalled clock enable cannot fake a long busy
  always_ff @(posedge clk_sys_i) busy_cnt <= (rst_i || !busy) ? 16'h0 : busy_cnt + 16'(ce_i);
  sequence pin_held_low; !write_protect_n_i [*4]; endsequence
  sequence op_started; array_op_o != AOP_NONE; endsequence
  a_reset_clears_state: assert property (disable iff (1'b0) rst_i |=>
    flash_status_o == 8'h00 && array_op_o == AOP_NONE && !deep_sleep_o)
    else $error("state not cleared by reset");
  a_reserved_bits_zero: assert property (flash_status_o[6:5] == 2'b00)
    else $error("reserved status bits set");
  a_op_needs_latch: assert property (op_started |-> $past(flash_status_o[ST_WEL_BIT]))
    else $error("array op without latch");
  a_op_raises_busy: assert property (op_started |-> ##[0:1] busy)
    else $error("array op without busy");
  a_busy_cycle_length: assert property ($fell(busy) |->
    busy_cnt inside {[BUSY_CYCLES - 16'd2 : BUSY_CYCLES + 16'd1]})
    else $error("busy length wrong");
  a_busy_end_latch: assert property ($fell(busy) |-> !flash_status_o[ST_WEL_BIT])
    else $error("latch kept after write cycle");
  a_chip_erase_unprotected: assert property (array_op_o == AOP_ERASE_CHIP |->
    flash_status_o[ST_SEL_MSB:ST_SEL_LSB] == 3'h0)
    else $error("chip erase while protected");
  a_sleep_no_op: assert property (deep_sleep_o |-> array_op_o == AOP_NONE)
    else $error("array op in deep sleep");
  a_lock_freezes_bits: assert property (pin_held_low ##0 flash_status_o[7] && !busy |=>
    $stable(flash_status_o[7:2]))
    else $error("locked bits changed");
  a_bits_need_write: assert property ($changed(flash_status_o[7:2]) |->
    busy || $past(busy))
    else $error("protect bits changed outside write");
  a_deselect_quiet: assert property (chip_select_n_i |->
    !dual_lane0_oe_o && !dual_lane1_oe_o)
    else $error("lane driven while deselected");
endmodule
bind flash_wp_status flash_wp_status_checker chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .chip_select_n_i(chip_select_n_i),
  .write_protect_n_i(write_protect_n_i), .dual_lane0_oe_o(dual_lane0_oe_o),
  .dual_lane1_oe_o(dual_lane1_oe_o), .array_op_o(array_op_o),
  .flash_status_o(flash_status_o), .deep_sleep_o(deep_sleep_o));

//--- flash_wp_status_tb.sv
// Self-checking bench for the serial flash protection and status logic
`timescale 1ns/100ps
module flash_wp_status_tb;
  import flash_wp_pkg::*;
  // ****************************************************************
  // Bench
  // ****************************************************************
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        write_protect_n_i = 1'b1;
  logic [7:0]  array_rdata_i = 8'h00;
  wire logic   sclk, cs_n, mosi, lane0_w, lane1_w;
  logic        lane0_o, lane0_oe, lane1_o, lane1_oe, deep_sleep_o;
  logic [23:0] array_raddr_o, array_addr_o, last_addr;
  logic [2:0]  array_op_o, last_op;
  logic [7:0]  flash_status_o;
  logic [31:0] rx0, rx1;
  int          errors = 0, checked = 0, ops = 0, cycles = 0;
  logic [23:0] tops [8] = '{24'h0, 24'h07dfff, 24'h07bfff, 24'h077fff,
                            24'h06ffff, 24'h05ffff, 24'h03ffff, 24'h07ffff};
  logic [7:0]  opc [6] = '{OP_PAGE_PROG, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K,
                           OP_CHIP_ERASE1, OP_CHIP_ERASE2};
  int          len [6] = '{5, 4, 4, 4, 1, 1};
  // Lane 1 shows the inverse when nobody drives it, so a missing enable cannot pass; lane 0 shows mosi
  assign lane0_w = lane0_oe ? lane0_o : mosi;
  assign lane1_w = lane1_oe ? lane1_o : ~lane1_o;
  flash_wp_status #(.DENSITY_4M(1'b1)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .sclk_i(sclk),
    .chip_select_n_i(cs_n), .write_protect_n_i(write_protect_n_i),
    .dual_lane0_i(lane0_w), .dual_lane0_o(lane0_o), .dual_lane0_oe_o(lane0_oe),
    .dual_lane1_o(lane1_o), .dual_lane1_oe_o(lane1_oe), .array_rdata_i(array_rdata_i),
    .array_raddr_o(array_raddr_o), .array_op_o(array_op_o), .array_addr_o(array_addr_o),
    .flash_status_o(flash_status_o), .deep_sleep_o(deep_sleep_o));
  spi_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .lane0_i(lane0_w), .lane1_i(lane1_w));
  always #20 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i) begin
    array_rdata_i <= array_raddr_o[7:0] ^ 8'h5a;
    cycles++;
    if (array_op_o !== 3'h0) begin
      ops++;
      last_op = array_op_o;
      last_addr = array_addr_o;
    end
    if (cycles == 60000) begin
      errors++;
      tally_and_finish();
    end
  end
  function automatic logic [7:0] st(logic lock, logic [2:0] sel, logic write_enable_latch, logic busy);
    return {lock, 2'b00, sel, write_enable_latch, busy};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input logic [39:0] d, input int nsend, input int ntotal = 0);
    host.frame(d, nsend, (ntotal > nsend) ? ntotal : nsend, rx0, rx1);
    repeat (8) @(negedge clk_sys_i);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100 && flash_status_o[ST_BUSY_BIT] !== 1'b0; i++) @(negedge clk_sys_i);
  endtask
  task automatic set_status(input logic [7:0] v);
    send({OP_SET_WEL, 32'h0}, 8);
    send({OP_STAT_WR, v, 24'h0}, 16);
    wait_idle();
  endtask
  task automatic try_erase(input logic [23:0] a, input int ok, input logic [2:0] sel);
    int n;
    send({OP_SET_WEL, 32'h0}, 8);
    n = ops;
    send({OP_ERASE_4K, a, 8'h00}, 32);
    check("erase taken", ops, n + ok);
    check("erase status", flash_status_o, st(1'b0, sel, 1'b1, ok[0]));
    wait_idle();
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    int n;
    repeat (6) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    check("reset status", flash_status_o, st(0, 0, 0, 0));
    send({OP_STAT_WR, 8'h1c, 24'h0}, 16);
    check("write without latch", flash_status_o, st(0, 0, 0, 0));
    send({OP_SET_WEL, 32'h0}, 8);
    check("latch set", flash_status_o, st(0, 0, 1, 0));
    send({OP_STAT_RD, 32'h0}, 8, 24);
    check("serial status", rx1[15:0], {2{st(0, 0, 1, 0)}});
    send({OP_CLR_WEL, 32'h0}, 8);
    check("latch clear", flash_status_o, st(0, 0, 0, 0));
    send({OP_SET_WEL, 32'h0}, 8);
    send({OP_PAGE_PROG, 24'h070000, 8'h11}, 39);
    check("partial frame", {ops[7:0], flash_status_o}, {8'h0, st(0, 0, 1, 0)});
    for (int i = 0; i < 6; i++) begin
      send({OP_SET_WEL, 32'h0}, 8);
      n = ops;
      send({opc[i], 24'h070000, 8'h5a}, 8 * len[i]);
      check("op kind", {ops[7:0], 5'h0, last_op}, {8'(n + 1), 5'h0, 3'(i < 4 ? i + 1 : 5)});
      if (len[i] > 1) check("op addr", last_addr, 24'h070000);
      check("op busy", flash_status_o, st(0, 0, 1, 1));
      wait_idle();
      check("after op", flash_status_o, st(0, 0, 0, 0));
    end
    // Freezing the system side holds busy while the link still answers
    send({OP_SET_WEL, 32'h0}, 8);
    send({OP_STAT_WR, 8'h04, 24'h0}, 16);
    ce_i = 1'b0;
    host.frame({OP_STAT_RD, 32'h0}, 8, 16, rx0, rx1);
    @(negedge clk_sys_i) ce_i = 1'b1;
    check("serial busy", rx1[1:0], 2'b11);
    wait_idle();
    for (int c = 1; c < 8; c++) begin
      set_status({3'b000, 3'(c), 2'b00});
      check("sel written", flash_status_o, st(0, 3'(c), 0, 0));
      try_erase(tops[c], 0, 3'(c));
      if (c < 7) try_erase(tops[c] + 24'h1, 1, 3'(c));
    end
    n = ops;
    send({OP_CHIP_ERASE2, 32'h0}, 8);
    check("chip erase refused", ops, n);
    set_status(8'h9c);
    @(negedge clk_sys_i) write_protect_n_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    set_status(8'h00);
    check("locked bits", flash_status_o[7:2], 6'h27);
    @(negedge clk_sys_i) write_protect_n_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    set_status(8'h00);
    check("unlocked write", flash_status_o, st(0, 0, 0, 0));
    send({OP_DEEP_SLEEP, 32'h0}, 8);
    send({OP_SET_WEL, 32'h0}, 8);
    check("sleep ignores", {deep_sleep_o, flash_status_o}, {1'b1, st(0, 0, 0, 0)});
    send({OP_WAKE, 32'h0}, 8);
    check("wake", deep_sleep_o, 1'b0);
    send({OP_DUAL_READ, 24'h0000c3, 8'h00}, 40, 44);
    check("dual byte", {rx1[3], rx0[3], rx1[2], rx0[2], rx1[1], rx0[1], rx1[0], rx0[0]},
          8'hc3 ^ 8'h5a);
    tally_and_finish();
  end
endmodule

//--- protect_decode.sv
// Decoder from protect_sel code and density to a protected address hit
`timescale 1ns/100ps
module protect_decode
  import flash_wp_pkg::*;
(
  input  wire logic [2:0]  sel_i,
  input  wire logic        dens_4m_i,
  input  wire logic [23:0] addr_i,
  output logic             hit_o
);

  logic [23:0] top;
  logic        none;

  always_comb begin
    none = 1'b0;
    top  = TOP2_ALL;
    if (dens_4m_i) begin
      case (sel_i)
        3'h1:    top = TOP4_SEL1;
        3'h2:    top = TOP4_SEL2;
        3'h3:    top = TOP4_SEL3;
        3'h4:    top = TOP4_SEL4;
        3'h5:    top = TOP4_SEL5;
        3'h6:    top = TOP4_SEL6;
        3'h7:    top = TOP4_ALL;
        default: none = 1'b1;
      endcase
    end else begin
      case (sel_i)
        3'h1:    top = TOP2_SEL1;
        3'h2:    top = TOP2_SEL2;
        3'h3:    top = TOP2_SEL3;
        3'h4:    top = TOP2_SEL4;
        3'h5:    top = TOP2_SEL5;
        3'h6,
        3'h7:    top = TOP2_ALL;
        default: none = 1'b1;
      endcase
    end
    // Every range starts at address zero
    hit_o = !none && (addr_i <= top);
  end

endmodule

//--- spi_host_model.sv
// Behavioural host controller that drives the serial flash link
`timescale 1ns/100ps
module spi_host_model (
  output logic     sclk_o,
  output logic     cs_n_o,
  output logic     mosi_o,
  input wire logic lane0_i,
  input wire logic lane1_i
);
  // ****************************************************************
  // Frame driver
  // ****************************************************************
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Clock stands still between frames; the odd offset keeps it off the system grid
  task automatic frame(input logic [39:0] d, input int nsend, input int ntotal,
                       output logic [31:0] rx0, output logic [31:0] rx1);
    rx0 = 32'h0;
    rx1 = 32'h0;
    #13.3 cs_n_o = 1'b0;
    #50;
    for (int i = 0; i < ntotal; i++) begin
      if (i < nsend) mosi_o = d[39 - i];
      else if (i == nsend) mosi_o = ~mosi_o;
      #62.5 sclk_o = 1'b1;
      rx0 = {rx0[30:0], lane0_i};
      rx1 = {rx1[30:0], lane1_i};
      #62.5 sclk_o = 1'b0;
    end
    #50 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #250;
  endtask
endmodule
